//--- rtl/fis_flash_ctrl.sv
// Flash control block: interrupts, stop hold-off, security and reset load.
//
// Overview of operation
// - Command interrupt when complete flag and enable set.
// - Error interrupt from enabled double or single fault.
// - Stop waits until the running command completes.
// - Security register loaded at reset from byte 0x3_FF0F.
// - Reprogrammed security byte applies after next reset.
// - Matching keys force security field to unsecure 10.
// - All-zero or all-ones keys never match.
// - Array reads invalid while key check runs.
// - Illegal key locks key command until reset.
// - Key check leaves stored bytes and protection alone.
// - Verified erase in special mode unsecures, enables debug.
// - Reset loads registers, errors give protected defaults.
// - Double fault at reset sets both verify bits.
// - Complete flag clear during reset load, set after.
// - Hold accesses first, then ignore command writes.
// - Reset aborts any command in progress.
`timescale 1ns/1ps
`include "fis_consts.svh"
module fis_flash_ctrl
    import fis_pkg::*;
#(
    parameter logic [7:0] CMD_ERASE_VERIFY_ALL = 8'h01,
    parameter logic [7:0] CMD_VERIFY_KEY       = 8'h0c
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic         hsel,
    input  wire logic [31:0]  haddr,
    input  wire logic [1:0]   htrans,
    input  wire logic         hwrite,
    input  wire logic [2:0]   hsize,
    input  wire logic [31:0]  hwdata,
    input  wire logic         hready,
    output logic              hreadyout,
    output logic              hresp,
    output logic [31:0]       hrdata,
    output fis_nvm_req_s      nvm_req,
    input  wire fis_nvm_rsp_s nvm_rsp,
    output fis_op_req_s       op_req,
    input  wire fis_op_rsp_s  op_rsp,
    input  wire logic         ecc_double_evt,
    input  wire logic         ecc_single_evt,
    input  wire logic         special_mode_pin,
    input  wire logic         stop_req,
    output logic              stop_ack,
    output logic              array_read_invalid,
    output logic              secured,
    output logic              debug_enable,
    output logic              cmd_irq,
    output logic              err_irq,
    output logic              irq
);

    typedef struct packed {
        fis_phase_e                          phase;
        logic [2:0]                          ld_idx;
        logic                                ld_err;
        logic                                ap_sel;
        logic                                ap_write;
        logic                                ap_rd_wait;
        logic [7:0]                          ap_addr;
        logic [31:0]                         hrdata;
        logic                                command_complete_flag;
        logic                                acc_err;
        logic [1:0]                          verify_fault_status;
        logic                                command_complete_irq_enable;
        logic                                double_fault_irq_enable;
        logic                                single_fault_irq_enable;
        logic                                double_fault_flag;
        logic                                single_fault_flag;
        logic [7:0]                          security_register;
        logic [7:0]                          program_array_protection;
        logic [7:0]                          data_array_protection;
        logic [7:0]                          option_register;
        logic [2:0]                          idx;
        logic [`FIS_CCOB_WORDS-1:0][15:0]    ccob;
        logic [`FIS_KEY_WORDS-1:0][15:0]     keys;
        logic                                key_ok;
        logic                                key_lock;
        logic                                dbg_en;
        logic [`FIS_IRQ_W-1:0]               irq_st;
        logic [`FIS_IRQ_W-1:0]               irq_msk;
        logic                                op_start;
        logic [7:0]                          op_code;
        logic                                nvm_en;
        logic [17:0]                         nvm_addr;
        logic                                mode_s1;
        logic                                mode_s2;
    } fis_state_s;

    fis_state_s s;
    fis_state_s next_s;

    logic                  accept;
    logic                  wr_go;
    logic                  launch;
    logic [`FIS_IRQ_W-1:0] irq_evt;
    logic [1:0]            kk;
    logic [15:0]           kw;
    logic                  kbad;

    // Address of the configuration word fetched at each load step.
    function automatic logic [17:0] ld_addr(input fis_phase_e ph, input logic [2:0] i);
        if (ph == FIS_HOLD) begin
            return (i == 3'h0) ? `FIS_ADDR_PROT : `FIS_ADDR_SEC;
        end
        return `FIS_ADDR_KEY0 + {14'h0, i[1:0], 1'b0, 1'b0} - {15'h0, i[1:0], 1'b0};
    endfunction

    always_comb begin
        next_s = s;
        irq_evt = '0;
        kk = s.ld_idx[1:0];
        kw = s.ccob[{1'b0, kk} + 3'h1];
        kbad = 1'b0;
        // Special mode strap is a pin: two flops before use.
        next_s.mode_s1 = special_mode_pin;
        next_s.mode_s2 = s.mode_s1;
        next_s.op_start = 1'b0;
        accept = hsel && htrans[1] && hready && hreadyout;
        wr_go = s.ap_sel && s.ap_write && hready;
        launch = 1'b0;

        // AHB address phase capture and read wait state.
        if (hready) begin
            next_s.ap_sel = accept;
            next_s.ap_write = hwrite;
            next_s.ap_addr = haddr[7:0];
            next_s.ap_rd_wait = accept && !hwrite;
        end
        if (s.ap_rd_wait) begin
            next_s.ap_rd_wait = 1'b0;
            case (s.ap_addr)
                `FIS_OFS_FLASH_STATUS_REGISTER: begin
                    next_s.hrdata = {24'h0, s.command_complete_flag, 1'b0, s.acc_err, 3'h0, s.verify_fault_status};
                end
                `FIS_OFS_FLASH_CONFIG_REGISTER: begin
                    next_s.hrdata = {24'h0, s.command_complete_irq_enable, 7'h0};
                end
                `FIS_OFS_FAULT_CONFIG_REGISTER: begin
                    next_s.hrdata = {30'h0, s.double_fault_irq_enable, s.single_fault_irq_enable};
                end
                `FIS_OFS_FAULT_STATUS_REGISTER: begin
                    next_s.hrdata = {30'h0, s.double_fault_flag, s.single_fault_flag};
                end
                `FIS_OFS_SECURITY_REGISTER: begin
                    next_s.hrdata = {24'h0, s.security_register};
                end
                `FIS_OFS_CIDX: begin
                    next_s.hrdata = {29'h0, s.idx};
                end
                `FIS_OFS_CDATA: begin
                    next_s.hrdata = (s.idx < 3'(`FIS_CCOB_WORDS)) ?
                                    {16'h0, s.ccob[s.idx]} : 32'h0;
                end
                `FIS_OFS_PROGRAM_ARRAY_PROTECTION: begin
                    next_s.hrdata = {24'h0, s.program_array_protection};
                end
                `FIS_OFS_DATA_ARRAY_PROTECTION: begin
                    next_s.hrdata = {24'h0, s.data_array_protection};
                end
                `FIS_OFS_OPTION_REGISTER: begin
                    next_s.hrdata = {24'h0, s.option_register};
                end
                `FIS_OFS_IRQST: begin
                    next_s.hrdata = {28'h0, s.irq_st};
                    next_s.irq_st = '0;
                end
                `FIS_OFS_IRQMSK: begin
                    next_s.hrdata = {28'h0, s.irq_msk};
                end
                default: begin
                    next_s.hrdata = 32'h0;
                end
            endcase
        end

        // Register writes in the data phase.
        if (wr_go) begin
            case (s.ap_addr)
                `FIS_OFS_FLASH_STATUS_REGISTER: begin
                    if (hwdata[`FIS_BIT_ACCERR]) begin
                        next_s.acc_err = 1'b0;
                    end
                    next_s.verify_fault_status = s.verify_fault_status & ~hwdata[1:0];
                    launch = hwdata[`FIS_BIT_COMMAND_COMPLETE_FLAG] && s.command_complete_flag && s.phase == FIS_IDLE;
                end
                `FIS_OFS_FLASH_CONFIG_REGISTER: begin
                    next_s.command_complete_irq_enable = hwdata[`FIS_BIT_COMMAND_COMPLETE_IRQ_ENABLE];
                end
                `FIS_OFS_FAULT_CONFIG_REGISTER: begin
                    next_s.double_fault_irq_enable = hwdata[1];
                    next_s.single_fault_irq_enable = hwdata[0];
                end
                `FIS_OFS_FAULT_STATUS_REGISTER: begin
                    next_s.double_fault_flag = s.double_fault_flag && !hwdata[1];
                    next_s.single_fault_flag = s.single_fault_flag && !hwdata[0];
                end
                `FIS_OFS_CIDX: begin
                    if (s.command_complete_flag) begin
                        next_s.idx = hwdata[2:0];
                    end
                end
                `FIS_OFS_CDATA: begin
                    if (s.command_complete_flag && s.idx < 3'(`FIS_CCOB_WORDS)) begin
                        next_s.ccob[s.idx] = hwdata[15:0];
                    end
                end
                `FIS_OFS_IRQMSK: begin
                    next_s.irq_msk = hwdata[`FIS_IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end

        if (launch) begin
            next_s.verify_fault_status = 2'h0;
            next_s.acc_err = 1'b0;
            if (s.ccob[0][15:8] == CMD_VERIFY_KEY) begin
                if (s.idx != `FIS_KEY_IDX || s.key_lock ||
                    s.security_register[7:6] != `FIS_KEYEN_ON) begin
                    next_s.acc_err = 1'b1;
                end else begin
                    next_s.command_complete_flag = 1'b0;
                    next_s.phase = FIS_KEYCHK;
                    next_s.ld_idx = 3'h0;
                    next_s.key_ok = 1'b1;
                end
            end else begin
                next_s.command_complete_flag = 1'b0;
                next_s.phase = FIS_RUN;
                next_s.op_start = 1'b1;
                next_s.op_code = s.ccob[0][15:8];
            end
        end

        case (s.phase)
            FIS_HOLD, FIS_KEYLD: begin
                if (nvm_rsp.valid) begin
                    if (nvm_rsp.dbl) begin
                        next_s.ld_err = 1'b1;
                        next_s.verify_fault_status = 2'h3;
                    end
                    next_s.ld_idx = s.ld_idx + 3'h1;
                    if (s.phase == FIS_HOLD) begin
                        if (s.ld_idx == 3'h0) begin
                            next_s.program_array_protection = nvm_rsp.data[15:8];
                            next_s.data_array_protection = nvm_rsp.data[7:0];
                        end else begin
                            next_s.option_register = nvm_rsp.data[15:8];
                            // low byte of 0x3_FF0E is 0x3_FF0F
                            next_s.security_register = nvm_rsp.data[7:0];
                        end
                        if (s.ld_idx == `FIS_HOLD_LAST) begin
                            next_s.phase = FIS_KEYLD;
                            next_s.ld_idx = 3'h0;
                        end
                    end else begin
                        next_s.keys[s.ld_idx[1:0]] = nvm_rsp.data;
                        if (s.ld_idx == `FIS_KEYLD_LAST) begin
                            if (s.ld_err || nvm_rsp.dbl) begin
                                next_s.security_register = `FIS_SECURITY_REGISTER_FALL;
                                next_s.program_array_protection = `FIS_PROT_FALL;
                                next_s.data_array_protection = `FIS_PROT_FALL;
                                next_s.option_register = `FIS_OPT_FALL;
                            end
                            next_s.command_complete_flag = 1'b1;
                            next_s.phase = FIS_IDLE;
                            next_s.nvm_en = 1'b0;
                            irq_evt[0] = 1'b1;
                        end
                    end
                end
            end
            FIS_RUN: begin
                if (op_rsp.done) begin
                    next_s.command_complete_flag = 1'b1;
                    next_s.verify_fault_status = op_rsp.err;
                    next_s.phase = FIS_IDLE;
                    irq_evt[0] = 1'b1;
                    if (s.op_code == CMD_ERASE_VERIFY_ALL && op_rsp.err == 2'h0 &&
                        s.mode_s2) begin
                        next_s.security_register[1:0] = `FIS_SEC_UNSEC;
                        next_s.dbg_en = 1'b1;
                    end
                end
            end
            FIS_KEYCHK: begin
                kbad = kw == `FIS_KEY_ZERO || kw == `FIS_KEY_ONES || kw != s.keys[kk];
                next_s.key_ok = s.key_ok && !kbad;
                next_s.ld_idx = s.ld_idx + 3'h1;
                if (kk == `FIS_KEY_LAST) begin
                    if (s.key_ok && !kbad) begin
                        next_s.security_register[1:0] = `FIS_SEC_UNSEC;
                    end else begin
                        next_s.key_lock = 1'b1;
                        next_s.acc_err = 1'b1;
                        irq_evt[3] = 1'b1;
                    end
                    next_s.command_complete_flag = 1'b1;
                    next_s.phase = FIS_IDLE;
                    irq_evt[0] = 1'b1;
                end
            end
            default: begin
            end
        endcase

        // Fault flags: a new event wins over a clear in the same cycle.
        if (ecc_double_evt) begin
            next_s.double_fault_flag = 1'b1;
            irq_evt[1] = 1'b1;
        end
        if (ecc_single_evt) begin
            next_s.single_fault_flag = 1'b1;
            irq_evt[2] = 1'b1;
        end
        next_s.irq_st = next_s.irq_st | irq_evt;
        next_s.nvm_addr = ld_addr(next_s.phase, next_s.ld_idx);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
            s.phase <= FIS_HOLD;
            s.nvm_en <= 1'b1;
            s.nvm_addr <= `FIS_ADDR_PROT;
            s.security_register <= `FIS_SECURITY_REGISTER_FALL;
            s.option_register <= `FIS_OPT_FALL;
        end else begin
            s <= next_s;
        end
    end

    assign hreadyout = !(s.phase == FIS_HOLD) && !s.ap_rd_wait;
    assign hresp = 1'b0;
    assign hrdata = s.hrdata;
    assign nvm_req = '{en: s.nvm_en, addr: s.nvm_addr};
    assign op_req = '{start: s.op_start, code: s.op_code};
    assign stop_ack = stop_req && s.command_complete_flag;
    assign array_read_invalid = s.phase == FIS_KEYCHK;
    assign secured = s.security_register[1:0] != `FIS_SEC_UNSEC;
    assign debug_enable = s.dbg_en;
    assign cmd_irq = s.command_complete_flag && s.command_complete_irq_enable;
    assign err_irq = (s.double_fault_flag && s.double_fault_irq_enable) || (s.single_fault_flag && s.single_fault_irq_enable);
    assign irq = |(s.irq_st & s.irq_msk);

endmodule // fis_flash_ctrl

//--- rtl/fis_consts.svh
// Register offsets, field positions, reset values and flash addresses.
`ifndef FIS_CONSTS_SVH
`define FIS_CONSTS_SVH
`define FIS_OFS_FLASH_STATUS_REGISTER    8'h00
`define FIS_OFS_FLASH_CONFIG_REGISTER    8'h04
`define FIS_OFS_FAULT_CONFIG_REGISTER  8'h08
`define FIS_OFS_FAULT_STATUS_REGISTER  8'h0c
`define FIS_OFS_SECURITY_REGISTER     8'h10
`define FIS_OFS_CIDX     8'h14
`define FIS_OFS_CDATA    8'h18
`define FIS_OFS_PROGRAM_ARRAY_PROTECTION    8'h1c
`define FIS_OFS_DATA_ARRAY_PROTECTION   8'h20
`define FIS_OFS_OPTION_REGISTER     8'h24
`define FIS_OFS_IRQST    8'h28
`define FIS_OFS_IRQMSK   8'h2c
`define FIS_BIT_COMMAND_COMPLETE_FLAG     7
`define FIS_BIT_ACCERR   5
`define FIS_BIT_COMMAND_COMPLETE_IRQ_ENABLE     7
`define FIS_CCOB_WORDS   6
`define FIS_KEY_WORDS    4
`define FIS_KEY_LAST     2'h3
`define FIS_KEY_IDX      3'h4
`define FIS_HOLD_LAST    3'h1
`define FIS_KEYLD_LAST   3'h3
`define FIS_ADDR_PROT    18'h3ff0c
`define FIS_ADDR_SEC     18'h3ff0e
`define FIS_ADDR_KEY0    18'h3ff00
`define FIS_SEC_UNSEC    2'h2
`define FIS_KEYEN_ON     2'h2
`define FIS_SECURITY_REGISTER_FALL    8'h03
`define FIS_PROT_FALL    8'h00
`define FIS_OPT_FALL     8'hff
`define FIS_KEY_ZERO     16'h0000
`define FIS_KEY_ONES     16'hffff
`define FIS_IRQ_W        4
`endif

//--- rtl/fis_pkg.sv
// Types shared by the flash control block.
package fis_pkg;
    typedef enum logic [2:0] {
        FIS_HOLD, FIS_KEYLD, FIS_IDLE, FIS_RUN, FIS_KEYCHK
    } fis_phase_e;
    typedef struct packed {
        logic        en;
        logic [17:0] addr;
    } fis_nvm_req_s;
    typedef struct packed {
        logic        valid;
        logic [15:0] data;
        logic        dbl;
    } fis_nvm_rsp_s;
    typedef struct packed {
        logic       start;
        logic [7:0] code;
    } fis_op_req_s;
    typedef struct packed {
        logic       done;
        logic [1:0] err;
    } fis_op_rsp_s;
endpackage

//--- verif/fis_flash_ctrl_checker.sv
// Port-level assertions for the flash control block.
`timescale 1ns/1ps
module fis_flash_ctrl_checker
    import fis_pkg::*;
(
    input wire logic         hclk,
    input wire logic         hresetn,
    input wire logic         hsel,
    input wire logic [1:0]   htrans,
    input wire logic         hwrite,
    input wire logic         hready,
    input wire logic         hreadyout,
    input wire fis_nvm_req_s nvm_req,
    input wire fis_op_req_s  op_req,
    input wire fis_op_rsp_s  op_rsp,
    input wire logic         stop_req,
    input wire logic         stop_ack,
    input wire logic         array_read_invalid,
    input wire logic         secured,
    input wire logic         debug_enable,
    input wire logic         cmd_irq
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_stop_busy;
        stop_ack |-> stop_req && !nvm_req.en && !array_read_invalid;
    endproperty
    a_stop_busy: assert property (p_stop_busy) else $error("stop granted while busy");
    property p_launch;
        op_req.start |-> !stop_ack ##1 !stop_ack;
    endproperty
    a_launch: assert property (p_launch) else $error("stop granted at launch");
    property p_key_len;
        $rose(array_read_invalid) |-> array_read_invalid[*4] ##1 !array_read_invalid;
    endproperty
    a_key_len: assert property (p_key_len) else $error("key check length wrong");
    property p_load_hold;
        nvm_req.en && nvm_req.addr == 18'h3ff0c |-> !hreadyout;
    endproperty
    a_load_hold: assert property (p_load_hold) else $error("bus open in hold");
    property p_load_flag;
        nvm_req.en |-> !cmd_irq;
    endproperty
    a_load_flag: assert property (p_load_flag) else $error("flag set during load");
    property p_rd_wait;
        hsel && htrans[1] && hready && !hwrite && hreadyout |=> !hreadyout ##1 hreadyout;
    endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
    property p_unsec;
        $fell(secured) |-> $past(array_read_invalid) || $past(op_rsp.done)
            || $past(nvm_req.en);
    endproperty
    a_unsec: assert property (p_unsec) else $error("unsecured without cause");
    property p_relock;
        $rose(secured) |-> $past(nvm_req.en);
    endproperty
    a_relock: assert property (p_relock) else $error("secured outside load");
    property p_debug;
        debug_enable |-> !secured;
    endproperty
    a_debug: assert property (p_debug) else $error("debug open while secured");

    c_key: cover property ($fell(array_read_invalid) ##1 !secured);
    c_op: cover property (op_rsp.done);
    c_stop: cover property ($rose(stop_ack));
endmodule // fis_flash_ctrl_checker

bind fis_flash_ctrl fis_flash_ctrl_checker u_fis_flash_ctrl_checker (
    .hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout, .nvm_req, .op_req,
    .op_rsp, .stop_req, .stop_ack, .array_read_invalid, .secured, .debug_enable, .cmd_irq
);

//--- verif/fis_far_model.sv
// Far-side model: configuration word store and command engine.
`timescale 1ns/1ps
module fis_far_model
    import fis_pkg::*;
(
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire fis_nvm_req_s     nvm_req,
    output fis_nvm_rsp_s          nvm_rsp,
    input  wire fis_op_req_s      op_req,
    output fis_op_rsp_s           op_rsp,
    input  wire logic [5:0][15:0] words,
    input  wire logic             dbl_on,
    input  wire logic [1:0]       op_err,
    input  wire logic [7:0]       dly
);
    logic [7:0] ncnt;
    logic [7:0] ocnt;
    logic       obusy;
    logic [2:0] idx;

    // Keys sit at word 0..3, protection at 4, option and security at 5.
    assign idx = nvm_req.addr[3] ? {2'b10, nvm_req.addr[1]} : {1'b0, nvm_req.addr[2:1]};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            nvm_rsp <= '0;
            op_rsp  <= '0;
            ncnt    <= '0;
            ocnt    <= '0;
            obusy   <= 1'b0;
        end else begin
            // Data and op error lines toggle when not qualified, dbl drops to 0, so stale values never match.
            nvm_rsp.valid <= 1'b0;
            nvm_rsp.dbl   <= 1'b0;
            nvm_rsp.data  <= ~nvm_rsp.data;
            op_rsp.done   <= 1'b0;
            op_rsp.err    <= ~op_rsp.err;
            if (nvm_req.en && !nvm_rsp.valid) begin
                ncnt <= ncnt + 8'h1;
                if (ncnt >= dly) begin
                    ncnt    <= '0;
                    nvm_rsp <= '{1'b1, words[idx], dbl_on};
                end
            end
            if (op_req.start) begin
                obusy <= 1'b1;
                ocnt  <= '0;
            end else if (obusy) begin
                ocnt <= ocnt + 8'h1;
                if (ocnt >= dly) begin
                    obusy  <= 1'b0;
                    op_rsp <= '{1'b1, op_err};
                end
            end
        end
    end
endmodule // fis_far_model

//--- verif/test_flash_irq_security_init.sv
// Self-checking bench for the flash control block.
`timescale 1ns/1ps
module test_flash_irq_security_init;
    import fis_pkg::*;
    logic             hreadyout, hresp, stop_ack, array_read_invalid, secured;
    logic             debug_enable, cmd_irq, err_irq, irq;
    logic [31:0]      hrdata, rdq, s;
    fis_nvm_req_s     nvm_req;
    fis_nvm_rsp_s     nvm_rsp;
    fis_op_req_s      op_req;
    fis_op_rsp_s      op_rsp;
    logic             hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0;
    logic [31:0]      haddr = '0, hwdata = '0;
    logic [1:0]       htrans = '0, op_err = '0;
    logic [2:0]       hsize = 3'h2;
    logic             ecc_double_evt = 1'b0, ecc_single_evt = 1'b0, dbl_on = 1'b0;
    logic             special_mode_pin = 1'b0, stop_req = 1'b0;
    logic [7:0]       dly = 8'h8;
    logic [5:0][15:0] words = '0;
    logic [63:0]      keys;
    int               mismatches = 0, n_tests = 0, cyc = 0;
    wire logic        hready = hreadyout;

    always #25 hclk = ~hclk;

    fis_flash_ctrl u_fis_flash_ctrl (.*);
    fis_far_model u_fis_far_model (.*);

    task automatic print_verdict();
        $display("comparisons=%0d mismatches=%0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    always @(posedge hclk) begin
        cyc++;
        if (cyc == 30000) begin
            mismatches++;
            print_verdict();
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // Ready is looked at before the edge, so the edge itself completes the phase.
    task automatic wt();
        do @(negedge hclk); while (hreadyout !== 1'b1);
        rdq = hrdata;
        @(posedge hclk);
    endtask

    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge hclk);
        haddr  <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        wt();
        htrans <= 2'b00;
        hwdata <= d;
        wt();
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(a, 1'b0, '0);
        chk(rdq & m, e);
    endtask

    task automatic wait_flag();
        for (int i = 0; i < 100; i++) begin
            bus(8'h00, 1'b0, '0);
            s = rdq;
            if (s[7]) break;
        end
        chk(s & 32'h80, 32'h80);
    endtask

    task automatic boot(input logic d);
        @(posedge hclk);
        dbl_on  <= d;
        hresetn <= 1'b0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
    endtask

    task automatic pulse(input logic d);
        @(posedge hclk);
        ecc_double_evt <= d;
        ecc_single_evt <= !d;
        @(posedge hclk);
        ecc_double_evt <= 1'b0;
        ecc_single_evt <= 1'b0;
        @(negedge hclk);
    endtask

    task automatic launch(input logic [7:0] c, input int n, input logic [63:0] k, input logic b);
        bus(8'h14, 1'b1, 32'h0);
        bus(8'h18, 1'b1, {16'h0, c, 8'h0});
        for (int i = 1; i <= n; i++) begin
            bus(8'h14, 1'b1, 32'(i));
            bus(8'h18, 1'b1, {16'h0, k[16*(i-1)+:16]});
        end
        stop_req <= 1'b1;
        bus(8'h00, 1'b1, 32'h80);
        repeat (2) @(negedge hclk);
        chk(32'(stop_ack), 32'(!b));
        chk(32'(array_read_invalid), 32'(b && n == 4));
        wait_flag();
        chk(32'(stop_ack), 32'h1);
        @(posedge hclk);
        stop_req <= 1'b0;
    endtask

    initial begin
        void'($urandom(32'h6ec8bf36));
        for (int i = 0; i < 4; i++) keys[16*i+:16] = 16'($urandom_range(16'hfffe, 16'h0001));
        words <= {8'($urandom), 8'h83, 16'($urandom), keys};
        dly   <= 8'($urandom_range(12, 6));
        boot(1'b0);
        bus(8'h14, 1'b1, 32'h5);
        rdc(8'h00, 32'h80, 32'h0);
        wait_flag();
        rdc(8'h14, 32'h7, 32'h0);
        rdc(8'h1c, 32'hff, 32'(words[4][15:8]));
        rdc(8'h20, 32'hff, 32'(words[4][7:0]));
        rdc(8'h24, 32'hff, 32'(words[5][15:8]));
        rdc(8'h10, 32'hff, 32'h83);
        $display("test load done");
        bus(8'h04, 1'b1, 32'h80);
        @(negedge hclk);
        chk(32'(cmd_irq), 32'h1);
        bus(8'h04, 1'b1, 32'h0);
        @(negedge hclk);
        chk(32'(cmd_irq), 32'h0);
        for (int e = 0; e < 4; e++) begin
            bus(8'h08, 1'b1, e[1] ? 32'h3 : 32'h0);
            pulse(!e[0]);
            chk(32'(err_irq), 32'(e[1]));
            bus(8'h0c, 1'b1, 32'h3);
            @(negedge hclk);
            chk(32'(err_irq), 32'h0);
        end
        bus(8'h28, 1'b0, '0);
        bus(8'h2c, 1'b1, 32'h2);
        pulse(1'b1);
        chk(32'(irq), 32'h1);
        rdc(8'h28, 32'h2, 32'h2);
        @(negedge hclk);
        chk(32'(irq), 32'h0);
        $display("test interrupts done");
        launch(8'h0c, 4, keys, 1'b1);
        chk(32'(secured), 32'h0);
        rdc(8'h10, 32'hff, 32'h82);
        rdc(8'h1c, 32'hff, 32'(words[4][15:8]));
        boot(1'b0);
        wait_flag();
        rdc(8'h10, 32'hff, 32'h83);
        launch(8'h0c, 4, keys ^ 64'h1, 1'b1);
        rdc(8'h00, 32'h20, 32'h20);
        launch(8'h0c, 4, keys, 1'b0);
        chk(32'(secured), 32'h1);
        op_err <= 2'($urandom);
        launch(8'h02, 0, '0, 1'b1);
        rdc(8'h00, 32'h3, 32'(op_err));
        $display("test key lock done");
        words[0] <= 16'h0;
        special_mode_pin <= 1'b1;
        op_err <= 2'h0;
        boot(1'b0);
        wait_flag();
        launch(8'h0c, 4, {keys[63:16], 16'h0}, 1'b1);
        chk(32'(secured), 32'h1);
        launch(8'h01, 0, '0, 1'b1);
        chk(32'(secured), 32'h0);
        chk(32'(debug_enable), 32'h1);
        $display("test unsecure done");
        special_mode_pin <= 1'b0;
        bus(8'h18, 1'b1, 32'h0200);
        bus(8'h00, 1'b1, 32'h80);
        boot(1'b1);
        wait_flag();
        chk(s & 32'h83, 32'h83);
        rdc(8'h10, 32'hff, 32'h03);
        rdc(8'h1c, 32'hff, 32'h00);
        rdc(8'h24, 32'hff, 32'hff);
        chk(32'(secured), 32'h1);
        $display("test fallback done");
        print_verdict();
    end
endmodule // test_flash_irq_security_init
